/* hdl/clk_gate_pkg.sv */
// shared constants for peripheral clock gating and soft reset control
// assumes a 32-bit register port with a 12-bit byte address
package clk_gate_pkg;

  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;
  localparam int          PORT_CNT = 5;
  localparam int          IRQ_W    = 2;

  // register byte offsets
  localparam logic [11:0] SOFT_RESET_CONTROL_0_OFS       = 12'h040;
  localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFS = 12'h128;
  localparam logic [11:0] IRQ_STATUS_OFS                 = 12'h1a0;
  localparam logic [11:0] IRQ_MASK_OFS                   = 12'h1a4;
  localparam logic [11:0] GATE_VIEW_OFS                  = 12'h1a8;

  // port gate field positions, port e highest
  localparam int          PORT_A_CLOCK_GATE_BIT = 0;
  localparam int          PORT_B_CLOCK_GATE_BIT = 1;
  localparam int          PORT_C_CLOCK_GATE_BIT = 2;
  localparam int          PORT_D_CLOCK_GATE_BIT = 3;
  localparam int          PORT_E_CLOCK_GATE_BIT = 4;

  // soft reset field positions
  localparam int          PWM_RESET_BIT      = 20;
  localparam int          ADC0_RESET_BIT     = 16;
  localparam int          WATCHDOG_RESET_BIT = 3;

  // writable bits and reset values
  localparam logic [31:0] SOFT_RESET_RW_MASK = 32'h0011_0008;
  localparam logic [31:0] SOFT_RESET_RST_VAL = 32'h0000_0000;
  localparam logic [4:0]  PORT_GATE_RST_VAL  = 5'h00;
  localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

  // interrupt status layout
  localparam int          IRQ_GATED_ACCESS_BIT = 0;
  localparam int          IRQ_ABSENT_WRITE_BIT = 1;
  localparam logic [1:0]  IRQ_RST_VAL          = 2'h0;

  // gate view layout: port enables low, mode above
  localparam int          VIEW_MODE_LSB = 8;
  localparam int          VIEW_AUTO_BIT = 12;

  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP} power_mode_t;

endpackage

/* hdl/gate_select.sv */
// picks the gating vector that applies in the current power mode
// assumes mode and gate vectors come from logic on the same clock
`timescale 1ns/10ps
module gate_select
  import clk_gate_pkg::*;
#(
  parameter int NUM_PORTS = PORT_CNT
) (
  input  wire logic [NUM_PORTS-1:0] run_gate,
  input  wire logic [NUM_PORTS-1:0] sleep_gate,
  input  wire logic [NUM_PORTS-1:0] deep_gate,
  input  wire power_mode_t          mode,
  input  wire logic                 auto_gate,
  output wire logic [NUM_PORTS-1:0] active_gate
);

  // sleep tables only count with auto gating on; an illegal mode code falls back to run
  wire                 use_sleep = auto_gate && (mode == PM_SLEEP);
  wire                 use_deep  = auto_gate && (mode == PM_DEEP);

  assign active_gate = use_deep  ? deep_gate  :
                       use_sleep ? sleep_gate : run_gate;

endmodule

/* hdl/fault_check.sv */
// flags bus accesses to ports whose clock is gated off
// assumes access strobes are one-cycle pulses on the system clock
`timescale 1ns/10ps
module fault_check
  import clk_gate_pkg::*;
#(
  parameter int NUM_PORTS = PORT_CNT
) (
  input  wire logic [NUM_PORTS-1:0] access,
  input  wire logic [NUM_PORTS-1:0] clk_en,
  output wire logic [NUM_PORTS-1:0] fault_vec,
  output wire logic                 any_fault
);

  // one comparator per port
  genvar i;
  for (i = 0; i < NUM_PORTS; i++) begin : g_port
    assign fault_vec[i] = access[i] & ~clk_en[i];
  end

  assign any_fault = |fault_vec;

endmodule

/* hdl/periph_gate_ctrl.sv */
// peripheral clock gating and software reset control, register port slave
// assumes power mode, run/sleep tables and capability word come from the same clock
//
// Overview of operation
// R1: deep-sleep gate bits 4..0 enable ports e down to a.
// R2: a set gate bit clocks its port, a clear bit stops it.
// R3: an access to a gated-off port answers with a bus fault.
// R4: all gate bits read zero after reset, every port starts unclocked.
// R5: run, sleep or deep-sleep gate table applies by power mode.
// R6: sleep and deep-sleep tables apply only with automatic gating enabled.
// R7: deep-sleep gate bits 31:5 are read-only zero; software preserves them.
// R8: soft reset writes are masked by the capability word.
// R9: soft reset bit 20 resets the pwm unit.
// R10: soft reset bit 16 resets adc module 0.
// R11: soft reset bit 3 resets the watchdog.
// R12: other soft reset bits are read-only zero; software preserves them.
// R13: a unit stays in reset while its bit is one; reset clears all.
`timescale 1ns/10ps
module periph_gate_ctrl
  import clk_gate_pkg::*;
#(
  parameter int NUM_PORTS = PORT_CNT
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output wire logic [DATA_W-1:0]       reg_rdata,
  input  wire clk_gate_pkg::power_mode_t power_mode,
  input  wire logic                    auto_sleep_gating,
  input  wire logic [NUM_PORTS-1:0]    run_port_clock_gate,
  input  wire logic [NUM_PORTS-1:0]    sleep_port_clock_gate,
  input  wire logic [DATA_W-1:0]       capability_word_1,
  input  wire logic [NUM_PORTS-1:0]    port_access,
  output wire logic [NUM_PORTS-1:0]    port_clk_en,
  output wire logic                    bus_fault,
  output wire logic                    pwm_reset,
  output wire logic                    adc0_reset,
  output wire logic                    watchdog_reset,
  output wire logic                    irq
);
  import clk_gate_pkg::*;

  // the gate fields and the view register hold at most a byte of ports
  if (NUM_PORTS < 1 || NUM_PORTS > VIEW_MODE_LSB) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 8");
  end

  // state
  logic [NUM_PORTS-1:0] deep_gate_reg;
  logic [NUM_PORTS-1:0] deep_gate_next;
  logic [DATA_W-1:0]    soft_reset_reg;
  logic [DATA_W-1:0]    soft_reset_next;
  logic [NUM_PORTS-1:0] clk_en_reg;
  logic                 fault_reg;
  logic [IRQ_W-1:0]     irq_status_reg;
  logic [IRQ_W-1:0]     irq_status_next;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [IRQ_W-1:0]     irq_mask_next;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;

  wire  [NUM_PORTS-1:0] active_gate;
  wire  [NUM_PORTS-1:0] fault_vec;
  wire                  any_fault;

  // address decode
  wire hit_srst  = (reg_addr == SOFT_RESET_CONTROL_0_OFS);
  wire hit_deep  = (reg_addr == DEEP_SLEEP_PORT_CLOCK_GATE_OFS);
  wire hit_stat  = (reg_addr == IRQ_STATUS_OFS);
  wire hit_mask  = (reg_addr == IRQ_MASK_OFS);
  wire hit_view  = (reg_addr == GATE_VIEW_OFS);

  wire wr_srst   = reg_wr && hit_srst;
  wire wr_deep   = reg_wr && hit_deep;
  wire wr_stat   = reg_wr && hit_stat;
  wire wr_mask   = reg_wr && hit_mask;

  // pick the gating table for the present power mode
  gate_select #(
    .NUM_PORTS   (NUM_PORTS)
  ) u_gate_select (
    .run_gate    (run_port_clock_gate),
    .sleep_gate  (sleep_port_clock_gate),
    .deep_gate   (deep_gate_reg),
    .mode        (power_mode),
    .auto_gate   (auto_sleep_gating),
    .active_gate (active_gate)
  ); // see R5, see R6

  // compare access strobes against the enables actually in force
  fault_check #(
    .NUM_PORTS (NUM_PORTS)
  ) u_fault_check (
    .access    (port_access),
    .clk_en    (clk_en_reg),
    .fault_vec (fault_vec),
    .any_fault (any_fault)
  ); // see R3

  // only bits both writable and present may change; absent units keep their value
  wire [DATA_W-1:0] srst_wmask  = SOFT_RESET_RW_MASK & capability_word_1; // see R8
  wire              absent_hit  = wr_srst &&
                                  |(reg_wdata & SOFT_RESET_RW_MASK & ~capability_word_1);

  // deep-sleep table takes only its port bits, upper bits do not exist
  assign deep_gate_next  = wr_deep ? reg_wdata[NUM_PORTS-1:0] : deep_gate_reg; // see R1, see R7

  assign soft_reset_next = wr_srst ?
                           ((soft_reset_reg & ~srst_wmask) | (reg_wdata & srst_wmask)) :
                           soft_reset_reg; // see R8, see R12

  // event set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_GATED_ACCESS_BIT] = any_fault;
  assign irq_events[IRQ_ABSENT_WRITE_BIT] = absent_hit;

  wire [IRQ_W-1:0] irq_clear = wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_RST_VAL;
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  assign irq_mask_next   = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_reg;

  // status view: enables in force, power mode and auto gating
  // built by shifts so each field sits at its own position whatever the port count
  wire [DATA_W-1:0] view_word = (DATA_W'(auto_sleep_gating) << VIEW_AUTO_BIT) |
                                (DATA_W'(power_mode) << VIEW_MODE_LSB) |
                                DATA_W'(clk_en_reg);

  // read mux, unmapped addresses and reserved bits read zero
  wire [DATA_W-1:0] rd_srst = soft_reset_reg;                         // see R12
  wire [DATA_W-1:0] rd_deep = DATA_W'(deep_gate_reg);                 // see R7
  wire [DATA_W-1:0] rd_stat = DATA_W'(irq_status_reg);
  wire [DATA_W-1:0] rd_mask = DATA_W'(irq_mask_reg);

  assign rdata_next = !reg_rd  ? READ_ZERO :
                      hit_srst ? rd_srst   :
                      hit_deep ? rd_deep   :
                      hit_stat ? rd_stat   :
                      hit_mask ? rd_mask   :
                      hit_view ? view_word : READ_ZERO;

  // configuration registers; reset leaves every port unclocked
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      deep_gate_reg  <= PORT_GATE_RST_VAL;  // see R4
      soft_reset_reg <= SOFT_RESET_RST_VAL; // see R13
      irq_mask_reg   <= IRQ_RST_VAL;
    end else if (ce) begin
      deep_gate_reg  <= deep_gate_next;
      soft_reset_reg <= soft_reset_next;
      irq_mask_reg   <= irq_mask_next;
    end
  end

  // enables in force are registered so the gate drivers see a clean level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_en_reg <= PORT_GATE_RST_VAL; // see R4
    end else if (ce) begin
      clk_en_reg <= active_gate;       // see R2, see R5
    end
  end

  // fault answer one cycle after the offending strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (ce) begin
      fault_reg <= any_fault; // see R3
    end
  end

  // sticky interrupt status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status_reg <= IRQ_RST_VAL;
    end else if (ce) begin
      irq_status_reg <= irq_status_next;
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= READ_ZERO;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign reg_rdata      = rdata_reg;
  assign port_clk_en    = clk_en_reg;                         // see R2
  assign bus_fault      = fault_reg;
  assign pwm_reset      = soft_reset_reg[PWM_RESET_BIT];      // see R9, see R13
  assign adc0_reset     = soft_reset_reg[ADC0_RESET_BIT];     // see R10, see R13
  assign watchdog_reset = soft_reset_reg[WATCHDOG_RESET_BIT]; // see R11, see R13
  assign irq            = |(irq_status_reg & irq_mask_reg);

  // checks

  a_port_e_order: assert property ( // see R1
    @(posedge sys_clk) disable iff (rst)
    ce |=> port_clk_en[PORT_E_CLOCK_GATE_BIT] == $past(active_gate[PORT_E_CLOCK_GATE_BIT])
  ) else $error("port e enable does not follow its gate bit");

  a_deep_gate_used: assert property ( // see R1
    @(posedge sys_clk) disable iff (rst)
    ce && auto_sleep_gating && power_mode == PM_DEEP && !wr_deep
    |=> port_clk_en == $past(deep_gate_reg)
  ) else $error("deep sleep enables not applied");

  a_gated_fault: assert property ( // see R3
    @(posedge sys_clk) disable iff (rst)
    ce && |(port_access & ~port_clk_en) |=> bus_fault
  ) else $error("access to gated port gave no fault");

  a_open_no_fault: assert property ( // see R3
    @(posedge sys_clk) disable iff (rst)
    ce && !(|(port_access & ~port_clk_en)) |=> !bus_fault
  ) else $error("fault raised for clocked port");

  a_reset_all_off: assert property ( // see R4
    @(posedge sys_clk)
    rst |=> port_clk_en == '0 && deep_gate_reg == '0 && !pwm_reset && !watchdog_reset
  ) else $error("state not cleared by reset");

  a_run_table_used: assert property ( // see R6
    @(posedge sys_clk) disable iff (rst)
    ce && !auto_sleep_gating |=> port_clk_en == $past(run_port_clock_gate)
  ) else $error("run table not applied without auto gating");

  a_sleep_table_used: assert property ( // see R5
    @(posedge sys_clk) disable iff (rst)
    ce && auto_sleep_gating && power_mode == PM_SLEEP
    |=> port_clk_en == $past(sleep_port_clock_gate)
  ) else $error("sleep table not applied");

  a_deep_rsvd_zero: assert property ( // see R7
    @(posedge sys_clk) disable iff (rst)
    ce && reg_rd && hit_deep |=> reg_rdata[DATA_W-1:NUM_PORTS] == '0
  ) else $error("deep sleep reserved bits not zero");

  a_absent_held: assert property ( // see R8
    @(posedge sys_clk) disable iff (rst)
    ce && wr_srst && !capability_word_1[PWM_RESET_BIT] |=> $stable(pwm_reset)
  ) else $error("absent unit reset bit changed");

  a_pwm_write: assert property ( // see R9
    @(posedge sys_clk) disable iff (rst)
    ce && wr_srst && capability_word_1[PWM_RESET_BIT]
    |=> pwm_reset == $past(reg_wdata[PWM_RESET_BIT])
  ) else $error("pwm reset bit not written");

  a_adc_write: assert property ( // see R10
    @(posedge sys_clk) disable iff (rst)
    ce && wr_srst && capability_word_1[ADC0_RESET_BIT]
    |=> adc0_reset == $past(reg_wdata[ADC0_RESET_BIT])
  ) else $error("adc reset bit not written");

  a_wdog_write: assert property ( // see R11
    @(posedge sys_clk) disable iff (rst)
    ce && wr_srst && capability_word_1[WATCHDOG_RESET_BIT]
    |=> watchdog_reset == $past(reg_wdata[WATCHDOG_RESET_BIT])
  ) else $error("watchdog reset bit not written");

  a_srst_rsvd_zero: assert property ( // see R12
    @(posedge sys_clk) disable iff (rst)
    ce && reg_rd && hit_srst |=> (reg_rdata & ~SOFT_RESET_RW_MASK) == '0
  ) else $error("soft reset reserved bits not zero");

  a_reset_held: assert property ( // see R13
    @(posedge sys_clk) disable iff (rst)
    pwm_reset && !wr_srst |=> pwm_reset
  ) else $error("pwm reset dropped without a write");

  a_fault_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && any_fault |=> irq_status_reg[IRQ_GATED_ACCESS_BIT]
  ) else $error("fault event lost from status");

endmodule

/* bench/test_periph_gate_ctrl.sv */
// self-checking bench for the clock gating and soft reset controller
// assumes the register port of the design and one 200 MHz clock
`timescale 1ns/10ps
module test_periph_gate_ctrl;
  import clk_gate_pkg::*;

  logic              sys_clk;
  logic              rst;
  logic              ce;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  power_mode_t       power_mode;
  logic              auto_sleep_gating;
  logic [4:0]        run_port_clock_gate;
  logic [4:0]        sleep_port_clock_gate;
  logic [DATA_W-1:0] capability_word_1;
  logic [4:0]        port_access;
  logic [4:0]        port_clk_en;
  logic              bus_fault;
  logic              pwm_reset;
  logic              adc0_reset;
  logic              watchdog_reset;
  logic              irq;
  int                error_cnt;
  int                checks_done;
  int                cycles;

  periph_gate_ctrl #(.NUM_PORTS(5)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode),
    .auto_sleep_gating(auto_sleep_gating), .run_port_clock_gate(run_port_clock_gate),
    .sleep_port_clock_gate(sleep_port_clock_gate), .capability_word_1(capability_word_1),
    .port_access(port_access), .port_clk_en(port_clk_en), .bus_fault(bus_fault),
    .pwm_reset(pwm_reset), .adc0_reset(adc0_reset), .watchdog_reset(watchdog_reset),
    .irq(irq)
  );

  // 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // each access leaves one idle cycle so no strobe is assigned twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask

  // change the selecting inputs, then let the registered enables follow
  task automatic apply(input power_mode_t m, input logic a);
    @(posedge sys_clk);
    power_mode        <= m;
    auto_sleep_gating <= a;
    @(posedge sys_clk);
    #1;
  endtask

  // one strobe, fault expected in the next cycle only
  task automatic hit(input logic [4:0] v, input logic exp);
    @(posedge sys_clk);
    port_access <= v;
    @(posedge sys_clk);
    port_access <= 5'h00;
    #1;
    chk("bus_fault", {31'h0, exp}, {31'h0, bus_fault});
  endtask

  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    power_mode = PM_RUN;
    auto_sleep_gating = 1'b0;
    run_port_clock_gate = 5'h05;
    sleep_port_clock_gate = 5'h0a;
    capability_word_1 = 32'hffff_ffff;
    port_access = 5'h00;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values
    rd(SOFT_RESET_CONTROL_0_OFS, 32'h0000_0000);
    rd(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0000);
    rd(IRQ_STATUS_OFS, 32'h0000_0000);
    rd(IRQ_MASK_OFS, 32'h0000_0000);
    apply(PM_DEEP, 1'b1);
    chk("port_clk_en", 32'h0, {27'h0, port_clk_en});
    // reserved gate bits are not stored
    wr(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'hffff_ffff);
    rd(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_001f);
    // table selection by mode and automatic gating
    apply(PM_DEEP, 1'b0);
    chk("port_clk_en", 32'h05, {27'h0, port_clk_en});
    apply(PM_SLEEP, 1'b1);
    chk("port_clk_en", 32'h0a, {27'h0, port_clk_en});
    apply(PM_RUN, 1'b1);
    chk("port_clk_en", 32'h05, {27'h0, port_clk_en});
    // the unused mode code falls back to the run table
    apply(power_mode_t'(2'h3), 1'b1);
    chk("port_clk_en", 32'h05, {27'h0, port_clk_en});
    apply(PM_DEEP, 1'b1);
    chk("port_clk_en", 32'h1f, {27'h0, port_clk_en});
    rd(GATE_VIEW_OFS, 32'h0000_121f);
    // each deep-sleep bit drives its own port
    for (int i = 0; i < 5; i++) begin
      wr(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h1 << i);
      @(posedge sys_clk);
      #1;
      chk("port_clk_en", 32'h1 << i, {27'h0, port_clk_en});
    end
    // only port c clocked now
    wr(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0004);
    @(posedge sys_clk);
    hit(5'h04, 1'b0);
    rd(IRQ_STATUS_OFS, 32'h0000_0000);
    hit(5'h01, 1'b1);
    hit(5'h1b, 1'b1);
    rd(IRQ_STATUS_OFS, 32'h0000_0001);
    // interrupt masked, unmasked, cleared
    chk("irq", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h0000_0003);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    wr(IRQ_STATUS_OFS, 32'h0000_0001);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    // soft reset bits with every unit present
    wr(SOFT_RESET_CONTROL_0_OFS, 32'hffff_ffff);
    rd(SOFT_RESET_CONTROL_0_OFS, 32'h0011_0008);
    chk("pwm_reset", 32'h1, {31'h0, pwm_reset});
    chk("adc0_reset", 32'h1, {31'h0, adc0_reset});
    chk("watchdog_reset", 32'h1, {31'h0, watchdog_reset});
    wr(SOFT_RESET_CONTROL_0_OFS, 32'h0000_0008);
    #1;
    chk("pwm_reset", 32'h0, {31'h0, pwm_reset});
    chk("watchdog_reset", 32'h1, {31'h0, watchdog_reset});
    // pwm marked absent: its bit ignores writes
    @(posedge sys_clk);
    capability_word_1 <= 32'hffef_ffff;
    wr(SOFT_RESET_CONTROL_0_OFS, 32'h0011_0000);
    rd(SOFT_RESET_CONTROL_0_OFS, 32'h0001_0000);
    chk("pwm_reset", 32'h0, {31'h0, pwm_reset});
    chk("irq", 32'h1, {31'h0, irq});
    rd(IRQ_STATUS_OFS, 32'h0000_0002);
    // unmapped place ignores writes, reads zero
    wr(12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0000_0000);
    // a frozen block takes no write
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(IRQ_MASK_OFS, 32'h0000_0000);
    ce <= 1'b1;
    rd(IRQ_MASK_OFS, 32'h0000_0003);
    chk("irq", 32'h1, {31'h0, irq});
    // second reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("adc0_reset", 32'h0, {31'h0, adc0_reset});
    chk("port_clk_en", 32'h0, {27'h0, port_clk_en});
    rd(DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0000);
    print_verdict();
  end
endmodule
